// ==== include/psdi_pkg.sv ====
// Purpose: Shared constants and types of the pseudo-static DRAM DDR slave interface.
// Assumes: Core clock of 125 MHz; the link clock is sampled, not used as a clock.
// Notes:   Command/address bit layout below is the block's own fixed choice.
package psdi_pkg;

    // ------------------------------------------------------------------
    // Command/address phase
    // ------------------------------------------------------------------
    localparam int         CA_BYTES       = 6;        // Six bytes over three link cycles.
    localparam logic [7:0] CA_LAST_EDGE   = 8'h05;    // Edge index of the sixth byte.
    localparam int         CA_READ_BIT    = 47;       // 1 = read, 0 = write.
    localparam int         CA_LINEAR_BIT  = 45;       // 1 = linear burst, 0 = wrapped.
    localparam int         CA_ROW_LSB     = 16;       // Row address from the first two cycles.
    localparam int         CA_COL_LSB     = 0;        // Word within the row from the third cycle.

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS      = 8;
    localparam int REFRESH_INTERVAL_NS  = 4000;
    localparam int REFRESH_TIME_NS      = 80;
    // A longest interval rounds down, a least busy time rounds up.
    localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_NS / CLOCK_PERIOD_NS;
    localparam int REFRESH_TIME_CYC     = (REFRESH_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------------
    localparam int         WORD_W     = 16;
    localparam logic [1:0] BUF_DEPTH  = 2'h2;         // Entries of the read buffer.

    // ------------------------------------------------------------------
    // Transaction states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PSDI_IDLE = 3'b000,
        PSDI_CA   = 3'b001,
        PSDI_LAT  = 3'b010,
        PSDI_RD   = 3'b011,
        PSDI_WR   = 3'b100
    } psdi_state_t;

endpackage

// ==== include/psdi_mem_if.sv ====
// Purpose: Word port between the transaction logic and the array model.
// Assumes: Both ends run on the core clock.
// Notes:   Read data comes back one cycle after rd_en.
`timescale 1ns/1ns
interface psdi_mem_if #(parameter int ADDR_W = 10);
    logic              rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [15:0]       rd_data;
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [15:0]       wr_data;
    logic [1:0]        wr_be;

    modport ctrl (output rd_en, rd_addr, wr_en, wr_addr, wr_data, wr_be, input rd_data);
    modport mem  (input rd_en, rd_addr, wr_en, wr_addr, wr_data, wr_be, output rd_data);
endinterface

// ==== logic/psdi_word_mem.sv ====
// Purpose: Word array with per-byte write enables and registered read data.
// Assumes: One read and one write port, same clock.
// Notes:   A read of a word written in the same cycle returns the old value.
`timescale 1ns/1ns
module psdi_word_mem #(
    parameter int ADDR_W = 10
) (
    input wire logic     clk,
    psdi_mem_if.mem      port
);
    localparam int DEPTH = 1 << ADDR_W;

    // ------------------------------------------------------------------
    // One byte lane per generate entry
    // ------------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_lane
        logic [7:0] bank_q [0:DEPTH-1];
        logic [7:0] rd_byte_q;

        // A masked lane keeps its stored byte.
        always_ff @(posedge clk) begin
            if (port.wr_en && port.wr_be[g]) begin
                bank_q[port.wr_addr] <= port.wr_data[8*g +: 8];
            end
            if (port.rd_en) begin
                rd_byte_q <= bank_q[port.rd_addr];
            end
        end

        assign port.rd_data[8*g +: 8] = rd_byte_q;
    end
endmodule // psdi_word_mem

// ==== logic/psdi_slave_top.sv ====
// Purpose: Slave-side transaction logic of a self-refreshing DRAM on a byte-wide DDR link.
// Assumes: Link pins are asynchronous to CLOCK and at least four times slower per half cycle.
// Notes:   Link edges are found by oversampling; outputs follow each edge by a few core cycles.
`timescale 1ns/1ns
module psdi_slave_top #(
    parameter int ADDR_W        = 10,   // Word address width of the array.
    parameter int COL_W         = 3,    // Word-within-row bits from the third cycle.
    parameter int WRAP_W        = 3,    // Wrap group of 2**WRAP_W words.
    parameter int LATENCY_COUNT = 6,    // Initial latency in link cycles.
    parameter bit DUAL_DIE      = 1'b1,
    parameter bit DIFF_CLOCK    = 1'b0  // Qualify the clock with its complement.
) (
    input  wire logic       CLOCK,
    input  wire logic       SRST,
    input  wire logic       CS_N,
    input  wire logic       LINK_CK,
    input  wire logic       CLOCK_COMPLEMENT,
    input  wire logic [7:0] DQ_IN,
    output logic      [7:0] DQ_OUT,
    output logic            DQ_OE,
    input  wire logic       STROBE_MASK_LINE_IN,
    output logic            STROBE_MASK_LINE_OUT,
    output logic            STROBE_MASK_LINE_OE
);
    localparam int ROW_W = ADDR_W - COL_W;
    localparam logic [7:0] LAT_SHORT_LAST = 8'(2 * LATENCY_COUNT - 1);
    localparam logic [7:0] LAT_LONG_LAST  = 8'(4 * LATENCY_COUNT - 1);
    localparam logic [15:0] REF_INT_LAST  = 16'(psdi_pkg::REFRESH_INTERVAL_CYC - 1);
    localparam logic [7:0]  REF_BUSY_LEN  = 8'(psdi_pkg::REFRESH_TIME_CYC);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic       cs_n_s1_q, cs_n_s2_q, ck_s1_q, ck_s2_q, cc_s1_q, cc_s2_q, ms_s1_q, ms_s2_q;
    logic [7:0] dq_s1_q, dq_s2_q;
    logic       ck_prev_q;

    // Data, mask and clock pass the same two stages, so the centring holds.
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            {cs_n_s1_q, cs_n_s2_q} <= 2'h3;
            {ck_s1_q, ck_s2_q, cc_s1_q, cc_s2_q, ms_s1_q, ms_s2_q} <= 6'h00;
            dq_s1_q <= 8'h00;
            dq_s2_q <= 8'h00;
        end else begin
            cs_n_s1_q <= CS_N;
            cs_n_s2_q <= cs_n_s1_q;
            ck_s1_q   <= LINK_CK;
            ck_s2_q   <= ck_s1_q;
            cc_s1_q   <= CLOCK_COMPLEMENT;
            cc_s2_q   <= cc_s1_q;
            ms_s1_q   <= STROBE_MASK_LINE_IN;
            ms_s2_q   <= ms_s1_q;
            dq_s1_q   <= DQ_IN;
            dq_s2_q   <= dq_s1_q;
        end
    end

    // In differential mode the clock counts high only when its complement is low.
    logic ck_lvl, ck_rise, ck_fall, ck_edge, sel;
    assign ck_lvl  = DIFF_CLOCK ? (ck_s2_q & ~cc_s2_q) : ck_s2_q;
    assign ck_rise = ck_lvl & ~ck_prev_q;
    assign ck_fall = ~ck_lvl & ck_prev_q;
    assign ck_edge = ck_rise | ck_fall;
    assign sel     = ~cs_n_s2_q;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ck_prev_q <= 1'b0;
        end else begin
            ck_prev_q <= ck_lvl;
        end
    end

    // ------------------------------------------------------------------
    // Transaction sequencer
    // ------------------------------------------------------------------
    psdi_pkg::psdi_state_t state_q;
    logic [7:0]  cnt_q;
    logic [47:0] ca_q;
    logic [47:0] ca_next;
    logic        long_q, is_read_q, linear_q, ref_pending_q;
    logic [7:0]  lat_last;

    assign ca_next  = {ca_q[39:0], dq_s2_q};
    assign lat_last = long_q ? LAT_LONG_LAST : LAT_SHORT_LAST;

    // Deselect aborts any phase; each command decides its own burst type.
    always_ff @(posedge CLOCK) begin
        if (SRST || !sel) begin
            state_q <= psdi_pkg::PSDI_IDLE;
            cnt_q   <= 8'h00;
        end else begin
            case (state_q)
                psdi_pkg::PSDI_IDLE: begin
                    state_q <= psdi_pkg::PSDI_CA;
                    cnt_q   <= 8'h00;
                end
                psdi_pkg::PSDI_CA: begin
                    if (ck_edge) begin
                        cnt_q <= (cnt_q == psdi_pkg::CA_LAST_EDGE) ? 8'h00 : cnt_q + 8'h01;
                        if (cnt_q == psdi_pkg::CA_LAST_EDGE) begin
                            state_q <= psdi_pkg::PSDI_LAT;
                        end
                    end
                end
                psdi_pkg::PSDI_LAT: begin
                    if (ck_edge) begin
                        cnt_q <= cnt_q + 8'h01;
                        if (cnt_q == lat_last) begin
                            state_q <= is_read_q ? psdi_pkg::PSDI_RD : psdi_pkg::PSDI_WR;
                        end
                    end
                end
                psdi_pkg::PSDI_RD, psdi_pkg::PSDI_WR: begin
                    state_q <= state_q; // Burst runs until select rises.
                end
                default: begin
                    state_q <= psdi_pkg::PSDI_IDLE;
                end
            endcase
        end
    end

    // Command bytes shift in on both edges; the latency choice is frozen at select.
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ca_q      <= 48'h0;
            long_q    <= 1'b0;
            is_read_q <= 1'b0;
            linear_q  <= 1'b0;
        end else if (state_q == psdi_pkg::PSDI_IDLE && sel) begin
            long_q <= DUAL_DIE | ref_pending_q;
        end else if (state_q == psdi_pkg::PSDI_CA && ck_edge) begin
            ca_q <= ca_next;
            if (cnt_q == psdi_pkg::CA_LAST_EDGE) begin
                is_read_q <= ca_next[psdi_pkg::CA_READ_BIT];
                linear_q  <= ca_next[psdi_pkg::CA_LINEAR_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Refresh engine
    // ------------------------------------------------------------------
    logic [15:0] ref_timer_q;
    logic [7:0]  ref_busy_q;
    logic        ref_ok, ref_due, ref_done;

    // Refresh may run while no data moves; an access in progress never sees it.
    assign ref_ok   = (state_q != psdi_pkg::PSDI_RD) && (state_q != psdi_pkg::PSDI_WR);
    assign ref_due  = (ref_timer_q == REF_INT_LAST);
    assign ref_done = (ref_busy_q == 8'h01);

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ref_timer_q   <= 16'h0000;
            ref_busy_q    <= 8'h00;
            ref_pending_q <= 1'b0;
        end else begin
            ref_timer_q <= ref_due ? 16'h0000 : ref_timer_q + 16'h0001;
            if (ref_busy_q != 8'h00) begin
                ref_busy_q <= ref_busy_q - 8'h01;
            end else if (ref_pending_q && ref_ok && state_q != psdi_pkg::PSDI_LAT) begin
                ref_busy_q <= REF_BUSY_LEN;
            end else if (ref_pending_q && state_q == psdi_pkg::PSDI_LAT && long_q && cnt_q < LAT_SHORT_LAST) begin
                ref_busy_q <= REF_BUSY_LEN; // early in latency so it ends before data moves.
            end
            // A new interval that ends as a refresh finishes keeps the request.
            if (ref_due) begin
                ref_pending_q <= 1'b1;
            end else if (ref_done) begin
                ref_pending_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Word addressing and array port
    // ------------------------------------------------------------------
    psdi_mem_if #(.ADDR_W(ADDR_W)) mem_port ();
    logic [ADDR_W-1:0] addr_q, addr_step;
    logic [1:0]        buf_cnt_q;
    logic              inflight_q, fetch;
    logic [7:0]        hi_byte_q;
    logic              hi_mask_q;
    logic              wr_en_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [15:0]       wr_data_q;
    logic [1:0]        wr_be_q;

    // Wrapped bursts keep the group bits and roll the low bits.
    assign addr_step = linear_q ? addr_q + 1'b1
                     : {addr_q[ADDR_W-1:WRAP_W], WRAP_W'(addr_q[WRAP_W-1:0] + 1'b1)};

    // Fetch ahead only while the buffer has room and no refresh holds the array.
    assign fetch = is_read_q && ref_busy_q == 8'h00
                && (state_q == psdi_pkg::PSDI_LAT || state_q == psdi_pkg::PSDI_RD)
                && (buf_cnt_q + {1'b0, inflight_q}) < psdi_pkg::BUF_DEPTH;

    // Addresses are whole words: row from the first two cycles, word from the third.
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            addr_q <= '0;
        end else if (state_q == psdi_pkg::PSDI_CA && ck_edge && cnt_q == psdi_pkg::CA_LAST_EDGE) begin
            addr_q <= {ca_next[psdi_pkg::CA_ROW_LSB +: ROW_W], ca_next[psdi_pkg::CA_COL_LSB +: COL_W]};
        end else if (fetch || (state_q == psdi_pkg::PSDI_WR && ck_fall)) begin
            addr_q <= addr_step;
        end
    end

    // Write bytes pair high-then-low; the mask of each lane is inverted into an enable.
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            hi_byte_q <= 8'h00;
            hi_mask_q <= 1'b1;
            wr_en_q   <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= 16'h0000;
            wr_be_q   <= 2'h0;
        end else begin
            wr_en_q <= (state_q == psdi_pkg::PSDI_WR) && sel && ck_fall;
            if (state_q == psdi_pkg::PSDI_WR && ck_rise) begin
                hi_byte_q <= dq_s2_q;
                hi_mask_q <= ms_s2_q;
            end
            if (state_q == psdi_pkg::PSDI_WR && ck_fall) begin
                wr_addr_q <= addr_q;
                wr_data_q <= {hi_byte_q, dq_s2_q};
                wr_be_q   <= ~{hi_mask_q, ms_s2_q};
            end
        end
    end

    assign mem_port.rd_en   = fetch;
    assign mem_port.rd_addr = addr_q;
    assign mem_port.wr_en   = wr_en_q;
    assign mem_port.wr_addr = wr_addr_q;
    assign mem_port.wr_data = wr_data_q;
    assign mem_port.wr_be   = wr_be_q;

    psdi_word_mem #(.ADDR_W(ADDR_W)) u_mem (
        .clk  (CLOCK),
        .port (mem_port)
    );

    // ------------------------------------------------------------------
    // Two-entry read buffer
    // ------------------------------------------------------------------
    logic [15:0] buf_q [0:1];
    logic        buf_wp_q, buf_rp_q;
    logic        in_valid, in_ready, out_valid, out_ready;

    // The host clock drains it, so a slow or stopped clock stalls the fetches.
    assign in_valid  = inflight_q;
    assign in_ready  = buf_cnt_q < psdi_pkg::BUF_DEPTH;
    assign out_valid = buf_cnt_q != 2'h0;
    assign out_ready = (state_q == psdi_pkg::PSDI_RD) && ck_fall;

    always_ff @(posedge CLOCK) begin
        if (SRST || state_q == psdi_pkg::PSDI_IDLE) begin
            inflight_q <= 1'b0;
            buf_cnt_q  <= 2'h0;
            buf_wp_q   <= 1'b0;
            buf_rp_q   <= 1'b0;
        end else begin
            inflight_q <= fetch;
            if (in_valid && in_ready) begin
                buf_q[buf_wp_q] <= mem_port.rd_data;
                buf_wp_q        <= ~buf_wp_q;
            end
            if (out_valid && out_ready) begin
                buf_rp_q <= ~buf_rp_q;
            end
            buf_cnt_q <= buf_cnt_q + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    // Strobe shows the latency choice during the command phase and toggles with read bytes.
    always_ff @(posedge CLOCK) begin
        if (SRST || !sel) begin
            DQ_OUT               <= 8'h00;
            DQ_OE                <= 1'b0;
            STROBE_MASK_LINE_OUT <= 1'b0;
            STROBE_MASK_LINE_OE  <= 1'b0;
        end else begin
            case (state_q)
                psdi_pkg::PSDI_IDLE: begin
                    STROBE_MASK_LINE_OE  <= 1'b1;
                    STROBE_MASK_LINE_OUT <= DUAL_DIE | ref_pending_q;
                end
                psdi_pkg::PSDI_CA: begin
                    if (ck_edge && cnt_q == psdi_pkg::CA_LAST_EDGE) begin
                        STROBE_MASK_LINE_OE  <= ca_next[psdi_pkg::CA_READ_BIT];
                        STROBE_MASK_LINE_OUT <= 1'b0;
                    end
                end
                psdi_pkg::PSDI_LAT: begin
                    if (ck_edge && cnt_q == lat_last) begin
                        DQ_OE <= is_read_q;
                    end
                end
                psdi_pkg::PSDI_RD: begin
                    if (ck_edge && out_valid) begin
                        DQ_OUT               <= ck_rise ? buf_q[buf_rp_q][15:8] : buf_q[buf_rp_q][7:0];
                        STROBE_MASK_LINE_OUT <= ~STROBE_MASK_LINE_OUT;
                    end
                end
                default: begin
                    STROBE_MASK_LINE_OE <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    sequence s_ca_done;
        state_q == psdi_pkg::PSDI_CA && ck_edge && cnt_q == psdi_pkg::CA_LAST_EDGE && sel;
    endsequence
    sequence s_read_byte;
        state_q == psdi_pkg::PSDI_RD && sel && ck_edge && out_valid;
    endsequence

    a_ca_strobe_level: assert property (state_q == psdi_pkg::PSDI_CA && sel && $past(state_q) == psdi_pkg::PSDI_CA
        |-> STROBE_MASK_LINE_OE && STROBE_MASK_LINE_OUT == long_q) else $error("strobe wrong in command phase");
    a_dual_die_long: assert property (DUAL_DIE && state_q == psdi_pkg::PSDI_LAT |-> lat_last == LAT_LONG_LAST)
        else $error("dual die without doubled latency");
    a_ca_six_edges: assert property (s_ca_done |=> state_q == psdi_pkg::PSDI_LAT && cnt_q == 8'h00)
        else $error("command phase did not end after six edges");
    a_read_strobe_toggle: assert property (s_read_byte |=> STROBE_MASK_LINE_OUT != $past(STROBE_MASK_LINE_OUT) && DQ_OE)
        else $error("read byte without strobe transition");
    a_write_mask_lane: assert property (state_q == psdi_pkg::PSDI_WR && ck_fall && sel
        |=> wr_en_q && wr_be_q[0] == !$past(ms_s2_q)) else $error("write mask not applied");
    a_wrap_in_group: assert property (fetch && !linear_q && state_q == psdi_pkg::PSDI_RD
        |=> addr_q[ADDR_W-1:WRAP_W] == $past(addr_q[ADDR_W-1:WRAP_W])) else $error("wrap left its group");
    a_linear_step: assert property (fetch && linear_q && state_q == psdi_pkg::PSDI_RD
        |=> addr_q == $past(addr_q) + 1'b1) else $error("linear burst did not step");
    a_refresh_quiet: assert property (ref_busy_q != 8'h00 |-> !mem_port.rd_en && !mem_port.wr_en)
        else $error("array accessed during refresh");
    a_release_lines: assert property (!sel ##1 !sel |-> !DQ_OE && !STROBE_MASK_LINE_OE)
        else $error("lines driven while deselected");
    a_buffer_bound: assert property (buf_cnt_q + {1'b0, inflight_q} <= psdi_pkg::BUF_DEPTH)
        else $error("read buffer overfilled");

endmodule // psdi_slave_top

// ==== testbench/psdi_host_model.sv ====
// Purpose: Host controller model that drives the link and collects read bytes.
// Assumes: 64 ns link clock and the doubled initial latency.
// Notes:   Lines released by the host show the inverse of their last value.
`timescale 1ns/1ns
module psdi_host_model #(
    parameter int LAT_EDGES = 24
) (
    output logic            cs_n,
    output logic            ck,
    output logic      [7:0] dq,
    output logic            mask,
    input  wire logic [7:0] dq_line,
    input  wire logic       strb,
    input  wire logic       strb_oe
);
    logic [15:0] wr_q [$];
    logic [1:0]  wm_q [$];
    logic [7:0]  rd_q [$];
    logic        in_data = 1'b0;

    // Idle frame state: select high and the clock parked low.
    initial begin
        cs_n = 1'b1;
        ck   = 1'b0;
        dq   = 8'h00;
        mask = 1'b0;
    end

    // Take a byte at each strobe transition; waiting 1 ns lets the byte settle.
    always @(strb) begin
        if (in_data) begin
            #1;
            if (strb_oe) rd_q.push_back(dq_line);
        end
    end

    // One frame of the given number of link edges.
    task automatic xfer(input logic [47:0] ca, input int edges, output logic lat);
        int i;
        int k;
        cs_n = 1'b0;
        #64;
        lat = strb_oe & strb;
        for (i = 0; i < edges; i++) begin
            k = i - 6 - LAT_EDGES;
            if (i < 6) dq = ca[47 - 8 * i -: 8];
            else if (k >= 0 && !ca[47]) begin
                dq   = k[0] ? wr_q[k / 2][7:0] : wr_q[k / 2][15:8];
                mask = wm_q[k / 2][k[0] ? 0 : 1];
            end
            in_data = (k >= 0);
            #16;
            ck = ~ck;
            #16;
        end
        #64;
        cs_n    = 1'b1;
        ck      = 1'b0;
        in_data = 1'b0;
        dq      = ~dq;
        mask    = ~mask;
        #64;
    endtask
endmodule // psdi_host_model

// ==== testbench/psram_ddr_slave_interface_tb.sv ====
// Purpose: Self-checking bench of the DDR slave transaction logic.
// Assumes: Default design parameters; 125 MHz core clock.
// Notes:   A shadow array predicts every word read back.
`timescale 1ns/1ns
module psram_ddr_slave_interface_tb;
    localparam int LAT_EDGES = 24;
    logic        clock = 1'b0;
    logic        srst  = 1'b1;
    logic        cs_n, lck, msk, so, soe, doe, lat, fill, strb;
    logic [7:0]  dqi, dqo, dqw;
    logic [15:0] shadow [1024];
    logic [15:0] exp_q [$];
    int          mismatches  = 0;
    int          checks_done = 0;
    int          j;

    // Core clock and the resolved levels of the two shared lines.
    always #4 clock = ~clock;
    assign dqw  = doe ? dqo : dqi;
    assign strb = soe ? so : msk;

    psdi_slave_top i_dut (.CLOCK(clock), .SRST(srst), .CS_N(cs_n), .LINK_CK(lck),
        .CLOCK_COMPLEMENT(~lck), .DQ_IN(dqw), .DQ_OUT(dqo), .DQ_OE(doe),
        .STROBE_MASK_LINE_IN(strb), .STROBE_MASK_LINE_OUT(so), .STROBE_MASK_LINE_OE(soe));
    psdi_host_model #(.LAT_EDGES(LAT_EDGES)) i_host (.cs_n(cs_n), .ck(lck), .dq(dqi),
        .mask(msk), .dq_line(dqw), .strb(strb), .strb_oe(soe));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Next word of a burst: linear steps on, wrapped rolls within its group of eight.
    function automatic logic [9:0] next_word(input logic [9:0] p, input logic lin);
        return lin ? p + 10'h001 : {p[9:3], p[2:0] + 3'h1};
    endfunction

    // One transaction; a nonzero cut sets the frame to that many edges and skips the read-back checks.
    task automatic burst(input logic rd, input logic lin, input logic [9:0] a, input int n, input int cut);
        logic [47:0] ca;
        logic [15:0] w;
        logic [1:0]  m;
        logic [9:0]  p;
        int          k;
        p = a;
        exp_q.delete();
        i_host.rd_q.delete();
        i_host.wr_q.delete();
        i_host.wm_q.delete();
        for (k = 0; k < n; k++) begin
            w = 16'($urandom);
            m = fill ? 2'h0 : 2'($urandom);
            if (rd) exp_q.push_back(shadow[p]);
            else begin
                i_host.wr_q.push_back(w);
                i_host.wm_q.push_back(m);
                if (!m[1]) shadow[p][15:8] = w[15:8];
                if (!m[0]) shadow[p][7:0] = w[7:0];
            end
            p = next_word(p, lin);
        end
        ca        = 48'h0;
        ca[47]    = rd;
        ca[45]    = lin;
        ca[22:16] = a[9:3];
        ca[2:0]   = a[2:0];
        @(posedge clock);
        #1;
        i_host.xfer(ca, (cut > 0) ? cut : 6 + LAT_EDGES + 2 * n, lat);
        check(16'(lat), 16'h0001);
        check(16'({doe, soe}), 16'h0000);
        if (rd && cut == 0) begin
            check(16'(i_host.rd_q.size()), 16'(2 * n));
            if (i_host.rd_q.size() == 2 * n)
                for (k = 0; k < n; k++) check({i_host.rd_q[2 * k], i_host.rd_q[2 * k + 1]}, exp_q[k]);
        end
    endtask

    // Main sequence: fill in bursts shorter than a refresh interval, masked wrap write, idle, reads, then six random reads or writes.
    initial begin
        fill = 1'b1;
        void'($urandom(53));
        repeat (4) @(posedge clock);
        #1 srst = 1'b0;
        check(16'({doe, soe}), 16'h0000);
        burst(1'b0, 1'b1, 10'h000, 32, 0);
        burst(1'b0, 1'b1, 10'h020, 32, 0);
        fill = 1'b0;
        burst(1'b0, 1'b0, 10'h00d, 8, 0);
        repeat (600) @(posedge clock);
        burst(1'b1, 1'b1, 10'h005, 12, 0);
        burst(1'b1, 1'b0, 10'h00e, 8, 0);
        burst(1'b1, 1'b1, 10'h020, 0, 37);
        for (j = 0; j < 6; j++) burst(1'($urandom), 1'($urandom), 10'($urandom % 48), 1 + $urandom % 8, 0);
        stop_test();
    end

    // Watchdog well beyond the expected run of about 27 us.
    initial begin
        #200000;
        mismatches++;
        stop_test();
    end
endmodule // psram_ddr_slave_interface_tb
